// ---- rtl/dee_access_ctl.sv ----
/*
 * Data EEPROM access control: address, data and control registers,
 * read strobe, unlock sequence and background byte write.
 * Assumes a byte array outside with a combinational read port on the
 * same clock, and register writes arriving as one-cycle strobes.
 */
// Operation
// - Addressed byte lands in data register for the next cycle.
// - Data register holds until next read or a software write.
// - Write starts only after the full unlock sequence, per byte.
// - Write trigger refused while program permit is clear.
// - Program permit is never cleared by hardware.
// - Permit and trigger set together does not start a write.
// - During a write, control, address and data writes are ignored.
// - Clearing permit during a write does not abort it.
// - Each byte write includes its own erase, no erase select needed.
// - Write runs in background without stalling the processor.
// - At write end, trigger clears and done flag sets.
// - Done flag stays set until software clears it.
`timescale 1ns/1ns
module dee_access_ctl
    import dee_pkg::*;
#(
    parameter logic [7:0]  UNLOCK_KEY1  = KEY1_DEF,
    parameter logic [7:0]  UNLOCK_KEY2  = KEY2_DEF,
    parameter int unsigned WRITE_CYCLES = WRITE_CYC_DEF
) (
    // Clock and reset
    input  wire logic             i_clk_sys,
    input  wire logic             i_rst,
    // Register write port
    input  wire logic             i_reg_we,
    input  wire logic [2:0]       i_reg_sel,
    input  wire logic [7:0]       i_reg_wdata,
    // Byte array
    input  wire logic [7:0]       i_mem_rdata,
    output logic      [EE_AW-1:0] o_mem_addr,
    output logic      [7:0]       o_mem_wdata,
    output logic                  o_mem_we,
    // Register views
    output logic      [7:0]       o_addr_low,
    output logic      [7:0]       o_addr_high,
    output logic      [7:0]       o_control,
    output logic      [7:0]       o_data_byte,
    output logic                  o_done_flag,
    output logic                  o_busy
);

    dee_state_t q;
    dee_state_t s;
    dee_tmr_if  tmr_if ();

    // ------------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------------
    function automatic logic sel_hit(input logic we, input logic [2:0] sel,
                                     input logic [2:0] want);
        sel_hit = we && (sel == want);
    endfunction : sel_hit

    function automatic logic key_hit(input logic we, input logic [2:0] sel,
                                     input logic [7:0] wdata, input logic [7:0] key);
        key_hit = sel_hit(we, sel, SEL_UNLOCK) && (wdata == key);
    endfunction : key_hit

    logic busy;
    logic ctl_wr;
    logic ee_region;
    logic wr_req;
    logic rd_req;
    logic start_ok;

    always_comb begin
        busy      = q.ctrl[CTL_WR];
        ctl_wr    = sel_hit(i_reg_we, i_reg_sel, SEL_CONTROL) && !busy;
        ee_region = (i_reg_wdata[CTL_REG_HI:CTL_REG_LO] == REGION_EE);
        wr_req    = ctl_wr && i_reg_wdata[CTL_WR];
        rd_req    = ctl_wr && i_reg_wdata[CTL_RD] && ee_region && !wr_req;
        // Permit must already be set from an earlier access
        start_ok  = wr_req && q.ctrl[CTL_PERMIT] && ee_region
                    && (q.ul == UL_ARMED);
    end

    // ------------------------------------------------------------------
    // Register strobes
    // ------------------------------------------------------------------
    logic key1_hit;
    logic key2_hit;
    logic addr_lo_wr;
    logic addr_hi_wr;
    logic data_wr;
    logic status_clr;

    always_comb begin
        key1_hit   = key_hit(i_reg_we, i_reg_sel, i_reg_wdata, UNLOCK_KEY1);
        key2_hit   = key_hit(i_reg_we, i_reg_sel, i_reg_wdata, UNLOCK_KEY2);
        // Holding registers lock while a write runs
        addr_lo_wr = sel_hit(i_reg_we, i_reg_sel, SEL_ADDR_LOW) && !busy;
        addr_hi_wr = sel_hit(i_reg_we, i_reg_sel, SEL_ADDR_HIGH) && !busy;
        data_wr    = sel_hit(i_reg_we, i_reg_sel, SEL_DATA) && !busy;
        status_clr = sel_hit(i_reg_we, i_reg_sel, SEL_STATUS)
                     && !i_reg_wdata[STA_DONE];
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        s           = q;
        s.mem_we    = 1'b0;
        s.tmr_start = 1'b0;

        // Unlock sequence, broken by any other access
        if (i_reg_we) begin
            case (q.ul)
                UL_IDLE: begin
                    if (key1_hit) begin
                        s.ul = UL_KEY1;
                    end else begin
                        s.ul = UL_IDLE;
                    end
                end
                UL_KEY1: begin
                    if (key2_hit) begin
                        s.ul = UL_ARMED;
                    end else begin
                        s.ul = UL_IDLE;
                    end
                end
                UL_ARMED: begin
                    s.ul = UL_IDLE;
                end
                default: begin
                    s.ul = UL_IDLE;
                end
            endcase
        end

        // Address and data holding registers
        if (addr_lo_wr) begin
            s.addr_low = i_reg_wdata;
        end
        if (addr_hi_wr) begin
            s.addr_high = i_reg_wdata;
        end
        if (data_wr) begin
            s.data = i_reg_wdata;
        end

        // Control register; read strobe is never stored
        if (ctl_wr) begin
            s.ctrl           = i_reg_wdata & CTL_KEEP;
            s.ctrl[CTL_WR]   = start_ok;
            s.tmr_start      = start_ok;
        end
        if (rd_req) begin
            s.data = i_mem_rdata;
        end

        // Done flag: software clears by writing zero
        if (status_clr) begin
            s.done = 1'b0;
        end

        // Write cycle end; set wins over a clear in the same cycle
        if (tmr_if.done) begin
            s.ctrl[CTL_WR] = 1'b0;
            s.done         = 1'b1;
            s.mem_we       = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            q           <= '0;
            q.ul        <= UL_IDLE;
            q.addr_low  <= RST_BYTE;
            q.addr_high <= RST_BYTE;
            q.ctrl      <= RST_BYTE;
            q.data      <= RST_BYTE;
            q.done      <= 1'b0;
            q.mem_we    <= 1'b0;
            q.tmr_start <= 1'b0;
        end else begin
            q <= s;
        end
    end

    // ------------------------------------------------------------------
    // Write timer
    // ------------------------------------------------------------------
    assign tmr_if.start = q.tmr_start;

    dee_wr_timer #(
        .CYCLES (WRITE_CYCLES)
    ) u_timer (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .tmr       (tmr_if)
    );

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign o_mem_addr  = {q.addr_high[EE_HI_W-1:0], q.addr_low};
    assign o_mem_wdata = q.data;
    assign o_mem_we    = q.mem_we;
    assign o_addr_low  = q.addr_low;
    assign o_addr_high = q.addr_high;
    assign o_control   = q.ctrl;
    assign o_data_byte = q.data;
    assign o_done_flag = q.done;
    assign o_busy      = q.ctrl[CTL_WR];

endmodule : dee_access_ctl

// ---- rtl/dee_pkg.sv ----
/*
 * Constants and state types for the data EEPROM access control block.
 * Assumes a single 20 MHz system clock and a byte-wide register write port.
 */
package dee_pkg;

    // ------------------------------------------------------------------
    // Clock and write cycle timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_FREQ_MHZ  = 20;
    localparam int unsigned WRITE_TIME_US = 4000;
    localparam int unsigned WRITE_CYC_DEF = WRITE_TIME_US * CLK_FREQ_MHZ;
    localparam int unsigned TMR_W         = 24;

    // ------------------------------------------------------------------
    // Register selects
    // ------------------------------------------------------------------
    localparam logic [2:0] SEL_ADDR_LOW  = 3'h0;
    localparam logic [2:0] SEL_ADDR_HIGH = 3'h1;
    localparam logic [2:0] SEL_CONTROL   = 3'h2;
    localparam logic [2:0] SEL_DATA      = 3'h3;
    localparam logic [2:0] SEL_UNLOCK    = 3'h4;
    localparam logic [2:0] SEL_STATUS    = 3'h5;

    // ------------------------------------------------------------------
    // Control and status fields
    // ------------------------------------------------------------------
    localparam int unsigned CTL_RD     = 0;
    localparam int unsigned CTL_WR     = 1;
    localparam int unsigned CTL_PERMIT = 2;
    localparam int unsigned CTL_ERASE  = 4;
    localparam int unsigned CTL_REG_LO = 6;
    localparam int unsigned CTL_REG_HI = 7;
    localparam logic [1:0]  REGION_EE  = 2'h0;
    localparam logic [7:0]  CTL_KEEP   = 8'hD4;
    localparam int unsigned STA_DONE   = 0;

    // ------------------------------------------------------------------
    // Memory geometry and reset values
    // ------------------------------------------------------------------
    localparam int unsigned EE_AW    = 10;
    localparam int unsigned EE_HI_W  = EE_AW - 8;
    localparam logic [7:0]  RST_BYTE = 8'h00;

    // ------------------------------------------------------------------
    // Default unlock keys
    // ------------------------------------------------------------------
    localparam logic [7:0] KEY1_DEF = 8'h55;
    localparam logic [7:0] KEY2_DEF = 8'hAA;

    // ------------------------------------------------------------------
    // State types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        UL_IDLE  = 2'b00,
        UL_KEY1  = 2'b01,
        UL_ARMED = 2'b10
    } dee_unlock_t;

    typedef struct packed {
        dee_unlock_t ul;
        logic [7:0]  addr_low;
        logic [7:0]  addr_high;
        logic [7:0]  ctrl;
        logic [7:0]  data;
        logic        done;
        logic        mem_we;
        logic        tmr_start;
    } dee_state_t;

    typedef struct packed {
        logic             run;
        logic [TMR_W-1:0] cnt;
        logic             done;
    } dee_tmr_state_t;

endpackage : dee_pkg

// ---- rtl/dee_tmr_if.sv ----
/*
 * Start and finish signals between the access control and its write timer.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ns
interface dee_tmr_if;
    logic start;
    logic done;

    modport ctl (output start, input  done);
    modport tmr (input  start, output done);
endinterface : dee_tmr_if

// ---- rtl/dee_wr_timer.sv ----
/*
 * Write cycle timer: counts a fixed number of clocks after a start pulse.
 * Assumes start is a one-cycle pulse that never arrives while running.
 */
`timescale 1ns/1ns
module dee_wr_timer
    import dee_pkg::*;
#(
    parameter int unsigned CYCLES = WRITE_CYC_DEF
) (
    // Clock and reset
    input  wire logic i_clk_sys,
    input  wire logic i_rst,
    // Control side
    dee_tmr_if.tmr    tmr
);

    dee_tmr_state_t q;
    dee_tmr_state_t s;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        s      = q;
        s.done = 1'b0;
        if (tmr.start) begin
            s.run = 1'b1;
            s.cnt = TMR_W'(CYCLES - 1);
        end else if (q.run) begin
            if (q.cnt == '0) begin
                s.run  = 1'b0;
                s.done = 1'b1;
            end else begin
                s.cnt = q.cnt - 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            q <= '0;
        end else begin
            q <= s;
        end
    end

    assign tmr.done = q.done;

endmodule : dee_wr_timer

// ---- sim/dee_access_ctl_checker.sv ----
/* Port assertions for the access control.
   Bound to every dee_access_ctl instance. */
`timescale 1ns/1ns
module dee_access_ctl_checker
    import dee_pkg::*;
#(
    parameter int unsigned WRITE_CYCLES = WRITE_CYC_DEF
) (
    // Clock and reset
    input wire logic       i_clk_sys,
    input wire logic       i_rst,
    // Register port
    input wire logic       i_reg_we,
    input wire logic [2:0] i_reg_sel,
    input wire logic [7:0] i_reg_wdata,
    input wire logic [7:0] i_mem_rdata,
    // Outputs
    input wire logic       o_mem_we,
    input wire logic [7:0] o_addr_low,
    input wire logic [7:0] o_addr_high,
    input wire logic [7:0] o_control,
    input wire logic [7:0] o_data_byte,
    input wire logic       o_done_flag,
    input wire logic       o_busy
);
    localparam int WB1 = WRITE_CYCLES + 1;
    localparam int WB2 = WRITE_CYCLES + 2;
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    // Consecutive cycles with the write busy
    int unsigned busy_len;
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            busy_len <= 0;
        end else if (o_busy) begin
            busy_len <= busy_len + 1;
        end else begin
            busy_len <= 0;
        end
    end

    // ----
    // Checks
    // ----
    property p_rd; i_reg_we && i_reg_sel == SEL_CONTROL && i_reg_wdata[1:0] == 2'h1
        && i_reg_wdata[7:6] == REGION_EE && !o_busy |=> o_data_byte == $past(i_mem_rdata);
    endproperty
    a_rd: assert property (p_rd) else $error("read byte wrong");
    property p_hold; !(i_reg_we && (i_reg_sel == SEL_DATA || i_reg_sel == SEL_CONTROL))
        |=> $stable(o_data_byte); endproperty
    a_hold: assert property (p_hold) else $error("data byte changed");
    property p_lock; o_busy && i_reg_we && i_reg_sel <= SEL_DATA |=> $stable(o_addr_low)
        && $stable(o_addr_high) && $stable(o_data_byte) && $stable(o_control[2]); endproperty
    a_lock: assert property (p_lock) else $error("write during busy taken");
    property p_perm; $fell(o_control[2]) |-> $past(i_reg_we) && $past(i_reg_sel) == SEL_CONTROL;
    endproperty
    a_perm: assert property (p_perm) else $error("permit cleared by itself");
    property p_start; $rose(o_busy) |-> $past(o_control[2]) && $past(i_reg_we)
        && $past(i_reg_sel) == SEL_CONTROL && $past(i_reg_wdata[1]); endproperty
    a_start: assert property (p_start) else $error("write started wrongly");
    property p_len; o_busy |-> busy_len <= WB1; endproperty
    a_len: assert property (p_len) else $error("busy too long");
    property p_end; $fell(o_busy) |-> busy_len == WB2 && o_mem_we && o_done_flag;
    endproperty
    a_end: assert property (p_end) else $error("write end wrong");
    property p_we; o_mem_we |-> $past(o_busy) && !o_busy; endproperty
    a_we: assert property (p_we) else $error("store outside write end");
    property p_dset; $rose(o_done_flag) |-> $fell(o_busy); endproperty
    a_dset: assert property (p_dset) else $error("done without write end");
    property p_dclr; $fell(o_done_flag) |-> $past(i_reg_we) && $past(i_reg_sel) == SEL_STATUS
        && !$past(i_reg_wdata[STA_DONE]); endproperty
    a_dclr: assert property (p_dclr) else $error("done cleared by itself");
endmodule : dee_access_ctl_checker

bind dee_access_ctl dee_access_ctl_checker #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_reg_we(i_reg_we), .i_reg_sel(i_reg_sel),
    .i_reg_wdata(i_reg_wdata), .i_mem_rdata(i_mem_rdata), .o_mem_we(o_mem_we),
    .o_addr_low(o_addr_low), .o_addr_high(o_addr_high), .o_control(o_control),
    .o_data_byte(o_data_byte), .o_done_flag(o_done_flag), .o_busy(o_busy));

// ---- sim/dee_access_ctl_tb.sv ----
/* Self-checking bench for the access control.
   Drives the register port and models the byte array. */
`timescale 1ns/1ns
module dee_access_ctl_tb
    import dee_pkg::*;
;
    logic             i_clk_sys = 1'b0;
    logic             i_rst = 1'b1;
    logic             i_reg_we = 1'b0;
    logic [2:0]       i_reg_sel = 3'h0;
    logic [7:0]       i_reg_wdata = 8'h00;
    logic [7:0]       i_mem_rdata, o_mem_wdata, o_addr_low, o_addr_high, o_control, o_data_byte;
    logic [EE_AW-1:0] o_mem_addr;
    logic             o_mem_we, o_done_flag, o_busy;
    logic [7:0]       mem [0:1023];
    int               failures = 0;
    int               n_tests = 0;
    int               cyc = 0;

    // ----
    // Clock, array model, timeout
    // ----
    always #25 i_clk_sys = ~i_clk_sys;
    assign i_mem_rdata = mem[o_mem_addr];
    always @(posedge i_clk_sys) begin
        if (o_mem_we === 1'b1) mem[o_mem_addr] <= o_mem_wdata;
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            failures++;
            results();
        end
    end

    dee_access_ctl #(.WRITE_CYCLES(8)) u_dee_access_ctl (
        .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_reg_we(i_reg_we), .i_reg_sel(i_reg_sel),
        .i_reg_wdata(i_reg_wdata), .i_mem_rdata(i_mem_rdata), .o_mem_addr(o_mem_addr),
        .o_mem_wdata(o_mem_wdata), .o_mem_we(o_mem_we), .o_addr_low(o_addr_low),
        .o_addr_high(o_addr_high), .o_control(o_control), .o_data_byte(o_data_byte),
        .o_done_flag(o_done_flag), .o_busy(o_busy));

    // ----
    // Tasks
    // ----
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [2:0] sel, input logic [7:0] d);
        @(posedge i_clk_sys);
        i_reg_we <= 1'b1;
        i_reg_sel <= sel;
        i_reg_wdata <= d;
        @(posedge i_clk_sys);
        i_reg_we <= 1'b0;
        #1;
    endtask : wr
    task automatic unlock(input logic [7:0] ctl);
        wr(SEL_UNLOCK, KEY1_DEF);
        wr(SEL_UNLOCK, KEY2_DEF);
        wr(SEL_CONTROL, ctl);
    endtask : unlock
    task automatic t_read;
        wr(SEL_ADDR_LOW, 8'h23);
        wr(SEL_ADDR_HIGH, 8'h03);
        wr(SEL_CONTROL, 8'h01);
        chk(o_data_byte, 8'h34);
        wr(SEL_ADDR_LOW, 8'h24);
        wr(SEL_CONTROL, 8'h41);
        chk(o_data_byte, 8'h34);
        wr(SEL_CONTROL, 8'h01);
        chk(o_data_byte, 8'h35);
    endtask : t_read
    task automatic t_refuse;
        unlock(8'h02);
        chk(o_control, 8'h00);
        unlock(8'h06);
        chk(o_control, 8'h04);
        wr(SEL_UNLOCK, KEY2_DEF);
        wr(SEL_UNLOCK, KEY1_DEF);
        wr(SEL_CONTROL, 8'h06);
        chk(o_control, 8'h04);
        wr(SEL_UNLOCK, KEY1_DEF);
        wr(SEL_ADDR_LOW, 8'h24);
        wr(SEL_UNLOCK, KEY2_DEF);
        wr(SEL_CONTROL, 8'h06);
        chk(o_control, 8'h04);
    endtask : t_refuse
    task automatic t_write;
        int k;
        wr(SEL_ADDR_LOW, 8'h55);
        wr(SEL_ADDR_HIGH, 8'h01);
        wr(SEL_DATA, 8'h3C);
        unlock(8'h06);
        chk(o_control, 8'h06);
        chk({7'h0, o_busy}, 8'h01);
        wr(SEL_DATA, 8'hFF);
        wr(SEL_ADDR_LOW, 8'h00);
        wr(SEL_ADDR_HIGH, 8'h02);
        wr(SEL_CONTROL, 8'h00);
        chk(o_data_byte, 8'h3C);
        chk(o_addr_low, 8'h55);
        chk(o_addr_high, 8'h01);
        chk(o_control, 8'h06);
        chk(o_mem_addr[7:0], 8'h55);
        chk(o_mem_wdata, 8'h3C);
        for (k = 0; k < 40 && o_done_flag !== 1'b1; k++) begin
            @(posedge i_clk_sys);
            #1;
        end
        chk({7'h0, o_done_flag}, 8'h01);
        chk(o_control, 8'h04);
        repeat (5) @(posedge i_clk_sys);
        chk(mem[10'h155], 8'h3C);
        chk(mem[10'h156], 8'h67);
        wr(SEL_STATUS, 8'h01);
        chk({7'h0, o_done_flag}, 8'h01);
        wr(SEL_STATUS, 8'h00);
        chk({7'h0, o_done_flag}, 8'h00);
        wr(SEL_CONTROL, 8'h05);
        chk(o_data_byte, 8'h3C);
        wr(SEL_CONTROL, 8'h06);
        chk(o_control, 8'h04);
        wr(SEL_CONTROL, 8'h00);
        chk(o_control, 8'h00);
    endtask : t_write
    task automatic results;
        $display("Tests: %0d Failures: %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : results

    initial begin
        for (int i = 0; i < 1024; i++) mem[i] = i[7:0] + 8'h11;
        repeat (20) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        #1;
        chk(o_control, 8'h00);
        chk(o_data_byte, 8'h00);
        t_read();
        t_refuse();
        t_write();
        results();
    end
endmodule : dee_access_ctl_tb
